// ### srwa_consts.vh
// Constants for the window detector and alignment calibration block
// What this block does
// - Step-fine bit picks coarse or fine spacing
// - Status bits 0 and 23 always read one
// - 24 status positions, select reaches first 16
// - Enable rise steps delays until edges align
// - Done flag raised when search completes
// - Found delay setting readable in status
// - Calibrated delay keeps applying afterwards
// - Search both invert settings, minimise coarse code
// - Status valid after three SYSREF rising edges
// - Status one flags violation, zero usable
`ifndef SRWA_CONSTS_VH
`define SRWA_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SRWA_ADDR_W 12
`define SRWA_ADDR_CLK_CTRL 12'h029
`define SRWA_ADDR_WIN_LOW 12'h02C
`define SRWA_ADDR_WIN_MID 12'h02D
`define SRWA_ADDR_WIN_HIGH 12'h02E
`define SRWA_ADDR_CAL_EN 12'h030
`define SRWA_ADDR_CAL_CFG 12'h031
`define SRWA_ADDR_CAL_STAT 12'h032
`define SRWA_ADDR_CAL_RES 12'h033
`define SRWA_ADDR_DLY_INV 12'h038
`define SRWA_ADDR_DLY_COARSE 12'h039
`define SRWA_ADDR_DLY_FINE 12'h03A

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SRWA_SEL_MSB 3
`define SRWA_FINE_BIT 4
`define SRWA_CFG_RST 8'h04
`define SRWA_WIN_W 24
`define SRWA_EDGES_VALID 2'h3
`define SRWA_COARSE_MAX 8'hFF

`endif

// ### srwa_sync.v
// Three-stage input synchroniser with two-stage agreement filter
`timescale 1ns/1ps
module srwa_sync #(
    parameter W = 1
) (
    input wire mclk,
    input wire nrst,
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    reg [W-1:0] out_ff;
    wire [W-1:0] agree;

    // Only stages two and three are compared; stage one may be metastable
    assign agree = ~(s2_ff ^ s3_ff);
    assign dout = out_ff;

    always @(posedge mclk) begin
        if (!nrst) begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            out_ff <= {W{1'b0}};
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= (s2_ff & agree) | (out_ff & ~agree);
        end
    end
endmodule // srwa_sync

// ### srwa_top.v
// Capture-window status, sample select and automatic delay alignment search
`timescale 1ns/1ps
`include "srwa_consts.vh"
module srwa_top (
    input wire mclk,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    output wire [7:0] reg_rdata,
    input wire sysref_in,
    input wire [23:0] window_raw,
    input wire align_phase,
    output wire [3:0] sample_position_select,
    output wire window_step_fine,
    output wire clock_invert_delay,
    output wire [7:0] coarse_delay_code,
    output wire [7:0] fine_delay_code,
    output wire align_cal_busy
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_SETTLE = 5'h02;
    localparam [4:0] ST_EVAL = 5'h04;
    localparam [4:0] ST_PICK = 5'h08;
    localparam [4:0] ST_DONE = 5'h10;

    wire sysref_s;
    wire align_s;
    wire [23:0] window_s;
    wire sysref_rise;
    wire launch;
    wire [3:0] settle_target;

    reg sysref_d_ff;
    reg [1:0] edge_cnt_ff;
    reg [23:0] win_ff;
    reg [4:0] ctrl_ff;
    reg cal_en_ff;
    reg cal_en_d_ff;
    reg [7:0] cal_cfg_ff;
    reg done_ff;
    reg res_inv_ff;
    reg [7:0] res_coarse_ff;
    reg dly_inv_ff;
    reg [7:0] dly_coarse_ff;
    reg [7:0] dly_fine_ff;
    reg [4:0] state_ff;
    reg srch_inv_ff;
    reg [7:0] srch_coarse_ff;
    reg [7:0] best0_ff;
    reg [3:0] settle_ff;
    reg [7:0] rdata_ff;
    reg [23:0] win_view;
    reg [7:0] nxt_rdata;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    srwa_sync #(.W(1)) u_sync_sysref (
        .mclk(mclk),
        .nrst(nrst),
        .din(sysref_in),
        .dout(sysref_s)
    );
    srwa_sync #(.W(1)) u_sync_align (
        .mclk(mclk),
        .nrst(nrst),
        .din(align_phase),
        .dout(align_s)
    );
    srwa_sync #(.W(`SRWA_WIN_W)) u_sync_win (
        .mclk(mclk),
        .nrst(nrst),
        .din(window_raw),
        .dout(window_s)
    );

    assign sysref_rise = sysref_s & ~sysref_d_ff;
    assign launch = cal_en_ff & ~cal_en_d_ff;
    // Zero settle count would never sample the detector, so it means one
    assign settle_target = (cal_cfg_ff[3:0] == 4'h0) ? 4'h1 : cal_cfg_ff[3:0];

    // ----------------------------------------------------------------
    // Capture window status
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (!nrst) begin
            sysref_d_ff <= 1'b0;
            edge_cnt_ff <= 2'h0;
            win_ff <= 24'hFFFFFF;
        end else begin
            sysref_d_ff <= sysref_s;
            if (sysref_rise) begin
                win_ff <= window_s;
                if (edge_cnt_ff != `SRWA_EDGES_VALID) begin
                    edge_cnt_ff <= edge_cnt_ff + 2'h1;
                end
            end
        end
    end

    // Until valid every position reads flagged, so nothing looks usable
    always @* begin
        win_view = 24'hFFFFFF;
        if (edge_cnt_ff == `SRWA_EDGES_VALID) begin
            win_view = win_ff;
        end
        win_view[0] = 1'b1;
        win_view[23] = 1'b1;
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (!nrst) begin
            ctrl_ff <= 5'h00;
            cal_en_ff <= 1'b0;
            cal_en_d_ff <= 1'b0;
            cal_cfg_ff <= `SRWA_CFG_RST;
            dly_inv_ff <= 1'b0;
            dly_coarse_ff <= 8'h00;
            dly_fine_ff <= 8'h00;
        end else begin
            cal_en_d_ff <= cal_en_ff;
            if (reg_wr && reg_addr == `SRWA_ADDR_CLK_CTRL) begin
                ctrl_ff <= reg_wdata[4:0];
            end
            if (reg_wr && reg_addr == `SRWA_ADDR_CAL_EN) begin
                cal_en_ff <= reg_wdata[0];
            end
            if (reg_wr && reg_addr == `SRWA_ADDR_CAL_CFG) begin
                cal_cfg_ff <= reg_wdata;
            end
            if (state_ff == ST_PICK) begin
                // Result lands in the delay fields so it outlives the enable
                dly_inv_ff <= (srch_coarse_ff < best0_ff) ? 1'b1 : 1'b0;
                dly_coarse_ff <= (srch_coarse_ff < best0_ff) ? srch_coarse_ff : best0_ff;
                dly_fine_ff <= 8'h00;
            end else if (reg_wr) begin
                if (reg_addr == `SRWA_ADDR_DLY_INV) begin
                    dly_inv_ff <= reg_wdata[0];
                end
                if (reg_addr == `SRWA_ADDR_DLY_COARSE) begin
                    dly_coarse_ff <= reg_wdata;
                end
                if (reg_addr == `SRWA_ADDR_DLY_FINE) begin
                    dly_fine_ff <= reg_wdata;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Alignment search
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            srch_inv_ff <= 1'b0;
            srch_coarse_ff <= 8'h00;
            best0_ff <= 8'h00;
            settle_ff <= 4'h0;
            done_ff <= 1'b0;
            res_inv_ff <= 1'b0;
            res_coarse_ff <= 8'h00;
        end else if (launch) begin
            state_ff <= ST_SETTLE;
            srch_inv_ff <= 1'b0;
            srch_coarse_ff <= 8'h00;
            settle_ff <= 4'h0;
            done_ff <= 1'b0;
        end else if (!cal_en_ff) begin
            // Abort leaves done low; a later launch restarts from scratch
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    state_ff <= ST_IDLE;
                end
                ST_SETTLE: begin
                    // Detector needs SYSREF edges at the new delay before it is trusted
                    if (sysref_rise) begin
                        settle_ff <= settle_ff + 4'h1;
                        if (settle_ff + 4'h1 >= settle_target) begin
                            state_ff <= ST_EVAL;
                        end
                    end
                end
                ST_EVAL: begin
                    settle_ff <= 4'h0;
                    if (align_s || srch_coarse_ff == `SRWA_COARSE_MAX) begin
                        if (!srch_inv_ff) begin
                            best0_ff <= srch_coarse_ff;
                            srch_inv_ff <= 1'b1;
                            srch_coarse_ff <= 8'h00;
                            state_ff <= ST_SETTLE;
                        end else begin
                            state_ff <= ST_PICK;
                        end
                    end else begin
                        srch_coarse_ff <= srch_coarse_ff + 8'h01;
                        state_ff <= ST_SETTLE;
                    end
                end
                ST_PICK: begin
                    // Tie keeps the non-inverted clock
                    res_inv_ff <= (srch_coarse_ff < best0_ff) ? 1'b1 : 1'b0;
                    res_coarse_ff <= (srch_coarse_ff < best0_ff) ? srch_coarse_ff
                        : best0_ff;
                    done_ff <= 1'b1;
                    state_ff <= ST_DONE;
                end
                ST_DONE: begin
                    state_ff <= ST_DONE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Delay outputs and read data
    // ----------------------------------------------------------------
    assign align_cal_busy = (state_ff == ST_SETTLE) || (state_ff == ST_EVAL)
        || (state_ff == ST_PICK);
    assign clock_invert_delay = align_cal_busy ? srch_inv_ff : dly_inv_ff;
    assign coarse_delay_code = align_cal_busy ? srch_coarse_ff : dly_coarse_ff;
    assign fine_delay_code = align_cal_busy ? 8'h00 : dly_fine_ff;
    assign sample_position_select = ctrl_ff[`SRWA_SEL_MSB:0];
    assign window_step_fine = ctrl_ff[`SRWA_FINE_BIT];
    assign reg_rdata = rdata_ff;

    always @* begin
        case (reg_addr)
            `SRWA_ADDR_CLK_CTRL: nxt_rdata = {3'h0, ctrl_ff};
            `SRWA_ADDR_WIN_LOW: nxt_rdata = win_view[7:0];
            `SRWA_ADDR_WIN_MID: nxt_rdata = win_view[15:8];
            `SRWA_ADDR_WIN_HIGH: nxt_rdata = win_view[23:16];
            `SRWA_ADDR_CAL_EN: nxt_rdata = {7'h00, cal_en_ff};
            `SRWA_ADDR_CAL_CFG: nxt_rdata = cal_cfg_ff;
            `SRWA_ADDR_CAL_STAT: nxt_rdata = {res_inv_ff, 6'h00, done_ff};
            `SRWA_ADDR_CAL_RES: nxt_rdata = res_coarse_ff;
            `SRWA_ADDR_DLY_INV: nxt_rdata = {7'h00, dly_inv_ff};
            `SRWA_ADDR_DLY_COARSE: nxt_rdata = dly_coarse_ff;
            `SRWA_ADDR_DLY_FINE: nxt_rdata = dly_fine_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end
endmodule // srwa_top

// ### srwa_monitor.sv
// Port checker for the window status and alignment search block
`timescale 1ns/1ps
module srwa_monitor (
    input wire mclk,
    input wire nrst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [3:0] sample_position_select,
    input wire window_step_fine,
    input wire clock_invert_delay,
    input wire [7:0] coarse_delay_code,
    input wire [7:0] fine_delay_code,
    input wire align_cal_busy
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    wire ctrl_wr = reg_wr && reg_addr == 12'h029;
    a_sel_write:
        assert property (ctrl_wr |=> sample_position_select == $past(reg_wdata[3:0]))
        else $error("select not taken");
    a_step_write:
        assert property (ctrl_wr |=> window_step_fine == $past(reg_wdata[4]))
        else $error("step fine not taken");
    a_rdata_hold:
        assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_edge_flag:
        assert property (reg_rd && reg_addr == 12'h02C |=> reg_rdata[0])
        else $error("position 0 not flagged");
    a_top_flag:
        assert property (reg_rd && reg_addr == 12'h02E |=> reg_rdata[7])
        else $error("position 23 not flagged");
    a_search_start:
        assert property ($rose(align_cal_busy) |-> coarse_delay_code == 8'h00 && !clock_invert_delay)
        else $error("search start wrong");
    a_coarse_step:
        assert property (align_cal_busy && $past(align_cal_busy) && $changed(coarse_delay_code)
            |-> coarse_delay_code == $past(coarse_delay_code) + 8'h01
            || coarse_delay_code == 8'h00 && clock_invert_delay)
        else $error("coarse step wrong");
    a_inv_order:
        assert property (align_cal_busy && $past(align_cal_busy) |-> !$fell(clock_invert_delay))
        else $error("invert went back");
    a_fine_zero:
        assert property (align_cal_busy |-> fine_delay_code == 8'h00)
        else $error("fine code moved in search");
    // Two cycles of write history: launch reaches the outputs late
    a_delay_hold:
        assert property (!align_cal_busy && !$past(align_cal_busy) && !reg_wr && !$past(reg_wr)
            && !$past(reg_wr, 2) |=> $stable({clock_invert_delay, coarse_delay_code}))
        else $error("applied delay drifted");
endmodule // srwa_monitor
bind srwa_top srwa_monitor u_srwa_monitor (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .sample_position_select, .window_step_fine, .clock_invert_delay,
    .coarse_delay_code, .fine_delay_code, .align_cal_busy);

// ### srwa_clk_src.sv
// Clock source model: periodic reference pulse, window flags, phase detector
`timescale 1ns/1ps
module srwa_clk_src #(
    parameter PERIOD = 16
) (
    input wire mclk,
    input wire run,
    input wire [23:0] flags,
    input wire [7:0] tgt0,
    input wire [7:0] tgt1,
    input wire clock_invert_delay,
    input wire [7:0] coarse_delay_code,
    output reg sysref_in = 1'b0,
    output wire [23:0] window_raw,
    output wire align_phase
);
    reg [7:0] cnt_ff = 8'h00;
    // No gaps in the pulse train once running
    always @(posedge mclk) begin
        cnt_ff <= (cnt_ff == PERIOD - 1) ? 8'h00 : cnt_ff + 8'h01;
        sysref_in <= run && (cnt_ff < PERIOD / 2);
    end
    assign window_raw = flags;
    // Link receiver not modelled; its buffer release point lies beyond this block
    assign align_phase = coarse_delay_code == (clock_invert_delay ? tgt1 : tgt0);
endmodule // srwa_clk_src

// ### testbench.sv
// Self-checking bench for the window status and alignment search block
`timescale 1ns/1ps
module testbench;
    reg mclk = 1'b0;
    reg nrst = 1'b0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg run = 1'b0;
    reg ei = 1'b0;
    reg [11:0] reg_addr = 12'h000;
    reg [23:0] flags = 24'h3C0F06;
    reg [7:0] reg_wdata = 8'h00, tgt0 = 8'h00, tgt1 = 8'h00, rv = 8'h00, ec = 8'h00;
    integer failures = 0;
    integer num_checks = 0;
    integer i, n;
    wire [7:0] reg_rdata, coarse_delay_code, fine_delay_code;
    wire [23:0] window_raw;
    wire [3:0] sample_position_select;
    wire sysref_in, align_phase, window_step_fine, clock_invert_delay, align_cal_busy;

    always #5 mclk = ~mclk;

    srwa_top u_srwa_top (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .sysref_in, .window_raw, .align_phase, .sample_position_select, .window_step_fine,
        .clock_invert_delay, .coarse_delay_code, .fine_delay_code, .align_cal_busy);
    srwa_clk_src u_srwa_clk_src (.mclk, .run, .flags, .tgt0, .tgt1, .clock_invert_delay,
        .coarse_delay_code, .sysref_in, .window_raw, .align_phase);

    // ------------------------------------------------------------
    // Register access, checks and final tally
    // ------------------------------------------------------------
    task chk(input [23:0] seen, input [23:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge mclk);
            reg_wr <= 1'b0;
            #1;
        end
    endtask
    task rd(input [11:0] a);
        begin
            @(posedge mclk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1 rv = reg_rdata;
        end
    endtask
    task rdc(input [11:0] a, input [7:0] exp);
        begin
            rd(a);
            chk({16'h0000, rv}, {16'h0000, exp});
        end
    endtask
    task tally_and_finish;
        begin
            if (failures == 0 && num_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        failures = failures + 1;
        tally_and_finish;
    end

    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        rdc(12'h029, 8'h00);
        rdc(12'h031, 8'h04);
        rdc(12'h02D, 8'hFF);
        run <= 1'b1;
        repeat (100) @(posedge mclk);
        rdc(12'h02C, 8'h07);
        rdc(12'h02D, 8'h0F);
        rdc(12'h02E, 8'hBC);
        wr(12'h02C, 8'h00);
        rdc(12'h02C, 8'h07);
        rdc(12'h0FF, 8'h00);
        wr(12'h029, 8'h1F);
        chk({19'h00000, window_step_fine, sample_position_select}, 24'h00001F);
        wr(12'h029, 8'h05);
        chk({19'h00000, window_step_fine, sample_position_select}, 24'h000005);
        wr(12'h029, 8'h00);
        // Targets: inverted wins, plain wins, tie goes to plain; zero settle count acts as one
        for (i = 0; i < 3; i = i + 1) begin
            tgt0 <= (i == 0) ? 8'h05 : (i == 1) ? 8'h03 : 8'h04;
            tgt1 <= (i == 0) ? 8'h02 : (i == 1) ? 8'h06 : 8'h04;
            wr(12'h030, 8'h00);
            wr(12'h031, (i == 2) ? 8'h00 : 8'h01);
            wr(12'h030, 8'h01);
            // Result invert bit keeps the previous outcome until the new search ends
            rdc(12'h032, {ei, 7'h00});
            ei = tgt1 < tgt0;
            ec = ei ? tgt1 : tgt0;
            for (n = 0; n < 600 && rv[0] !== 1'b1; n = n + 1)
                rd(12'h032);
            chk({16'h0000, rv}, {16'h0000, ei, 7'h01});
            rdc(12'h033, ec);
            repeat (50) @(posedge mclk);
            chk({7'h00, clock_invert_delay, coarse_delay_code, fine_delay_code},
                {7'h00, ei, ec, 8'h00});
        end
        wr(12'h030, 8'h00);
        wr(12'h039, 8'h33);
        chk({16'h0000, coarse_delay_code}, 24'h000033);
        wr(12'h038, 8'h01);
        wr(12'h03A, 8'h5A);
        chk({7'h00, clock_invert_delay, coarse_delay_code, fine_delay_code},
            {7'h00, 1'b1, 8'h33, 8'h5A});
        tally_and_finish;
    end
endmodule // testbench
